// ---- logic/epdsp_pkg.sv ----
// shared constants and types of the e-paper serial host port
package epdsp_pkg;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_DRV_OUT   = 8'h01;
  localparam logic [7:0] CMD_GATE_V    = 8'h03;
  localparam logic [7:0] CMD_RD_TEMP   = 8'h1B;
  localparam logic [7:0] CMD_RD_27     = 8'h27;
  localparam logic [7:0] CMD_RD_2D     = 8'h2D;
  localparam logic [7:0] CMD_RD_2E     = 8'h2E;
  localparam logic [7:0] CMD_RD_STATUS = 8'h2F;
  localparam logic [7:0] CMD_RD_35     = 8'h35;

  // ----------------------------------------
  // register reset values and fields
  // ----------------------------------------
  localparam logic [23:0] DRV_OUT_RST  = 24'h00_0127;
  localparam logic [7:0]  GATE_V_RST   = 8'h00;
  localparam int          DRV_TB_POS   = 16;
  localparam int          DRV_SM_POS   = 17;
  localparam int          DRV_GD_POS   = 18;
  localparam int          DRV_MUX_MSB  = 8;
  localparam int          GATE_V_MSB   = 4;
  localparam logic [8:0]  LAST_GATE    = 9'h127;
  localparam logic [8:0]  FIRST_GATE   = 9'h000;

  // ----------------------------------------
  // framing
  // ----------------------------------------
  localparam logic [3:0] LAST_BIT_4W = 4'h7;
  localparam logic [3:0] LAST_BIT_3W = 4'h8;
  localparam logic [2:0] TX_BITS     = 3'h7;
  localparam int         SYNC_W      = 6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RECV = 3'b010,
    ST_READ = 3'b100
  } epdsp_state_e;

  function automatic logic is_read_cmd(input logic [7:0] c);
    return (c == CMD_RD_TEMP) || (c == CMD_RD_27) || (c == CMD_RD_2D) ||
           (c == CMD_RD_2E) || (c == CMD_RD_STATUS) || (c == CMD_RD_35);
  endfunction

endpackage

// ---- logic/epdsp_byte_if.sv ----
// byte stream carrier between the port and its buffer
`timescale 1ns/1ps
interface epdsp_byte_if;
  logic       valid;
  logic       ready;
  logic       is_cmd;
  logic [7:0] data;
  modport src (output valid, output is_cmd, output data, input ready);
  modport snk (input valid, input is_cmd, input data, output ready);
endinterface

// ---- logic/epdsp_pin_sync.sv ----
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module epdsp_pin_sync #(
  parameter int N = 6
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  // pins
  input  wire logic [N-1:0] i_async,
  output logic      [N-1:0] o_sync
);
  logic [N-1:0] meta_reg;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule

// ---- logic/epdsp_two_buf.sv ----
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module epdsp_two_buf (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_clear,
  // streams
  epdsp_byte_if.snk in_if,
  epdsp_byte_if.src out_if
);
  logic [8:0] mem [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign in_if.ready  = (count_reg != 2'h2);
  assign out_if.valid = (count_reg != 2'h0);
  assign out_if.is_cmd = mem[rd_ptr_reg][8];
  assign out_if.data   = mem[rd_ptr_reg][7:0];
  assign push = in_if.valid && in_if.ready;
  assign pop  = out_if.valid && out_if.ready;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mem[0] <= 9'h000;
      mem[1] <= 9'h000;
    end else if (push) begin
      mem[wr_ptr_reg] <= {in_if.is_cmd, in_if.data};
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else if (i_clear) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- logic/epdsp_serial_host_port.sv ----
// serial host port of the e-paper controller: framing, read-back, setup
// Contract
// RL1: strap low picks 4-wire 8-bit framing, strap high 3-wire 9-bit.
// RL2: 4-wire: data pin sampled on serial clock rise, MSB first, 8 bits.
// RL3: host keeps command/data select steady over each 4-wire byte.
// RL4: finished byte is a command when select low, else parameter/data.
// RL5: reads: command byte with select low, then bytes read with select high.
// RL6: read bytes shifted out on falling clock edges, MSB first.
// RL7: 3-wire: host ties the select low; device ignores it.
// RL8: 3-wire: 9 bits per unit, flag first then byte MSB first.
// RL9: 3-wire: flag 0 means command, flag 1 means data.
// RL10: 3-wire read: command unit, then flag 1 before each 8-bit answer.
// RL11: host keeps serial clock under 20 MHz writing, 2.5 MHz reading.
// RL12: scan-direction bit set scans from last gate down, else from gate 0.
// RL13: serial pins only heeded while chip select is low.
// RL14: host sends nothing while busy is high.
// RL15: busy high while waveform runs or temperature sensor is talked to.
// RL16: bit counter cleared whenever chip select is high.
`timescale 1ns/1ps
module epdsp_serial_host_port (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // serial pins
  input  wire logic        i_active_low_reset_in,
  input  wire logic        i_bus_framing_strap,
  input  wire logic        i_cs_n,
  input  wire logic        i_dc,
  input  wire logic        i_sclk,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n,
  output logic             o_busy,
  // core status
  input  wire logic        i_waveform_active,
  input  wire logic        i_temp_sensor_active,
  // read-back
  input  wire logic [7:0]  i_read_data,
  output logic [7:0]       o_read_cmd,
  output logic             o_read_next,
  // received byte stream
  output logic             o_rx_valid,
  output logic             o_rx_is_cmd,
  output logic [7:0]       o_rx_data,
  input  wire logic        i_rx_ready,
  output logic             o_overrun,
  // gate setup
  output logic [23:0]      o_driver_output_setup,
  output logic [7:0]       o_gate_voltage_level,
  output logic             o_gate_scan_direction,
  output logic             o_first_gate_select,
  output logic             o_gate_interlace_mode,
  output logic [4:0]       o_positive_gate_voltage,
  output logic [8:0]       o_gate_mux_lines,
  output logic [8:0]       o_scan_start_gate
);

  // ----------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------
  logic [epdsp_pkg::SYNC_W-1:0] sync_v;
  logic strap_s;
  logic rstpin_s;
  logic cs_s;
  logic dc_s;
  logic sclk_s;
  logic sda_s;
  logic sclk_d_reg;
  logic rise;
  logic fall;
  logic soft_clr;

  epdsp_pin_sync #(.N(epdsp_pkg::SYNC_W)) u_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  ({i_bus_framing_strap, i_active_low_reset_in, i_cs_n,
                i_dc, i_sclk, i_sda}),
    .o_sync   (sync_v)
  );

  assign {strap_s, rstpin_s, cs_s, dc_s, sclk_s, sda_s} = sync_v;
  // pin reset acts synchronously, so a glitch-free release is not needed
  assign soft_clr = ~rstpin_s;
  // edges only count while selected
  assign rise = sclk_s & ~sclk_d_reg & ~cs_s; // RL13
  assign fall = ~sclk_s & sclk_d_reg & ~cs_s; // RL13

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) sclk_d_reg <= 1'b0;
    else sclk_d_reg <= sclk_s;
  end

  // ----------------------------------------
  // framing select
  // ----------------------------------------
  logic three_wire_reg;
  logic [3:0] last_idx;

  // only changes between transfers, so a unit never switches mid-way
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) three_wire_reg <= 1'b0;
    else if (cs_s) three_wire_reg <= strap_s; // RL1
  end

  assign last_idx = three_wire_reg ? epdsp_pkg::LAST_BIT_3W
                                   : epdsp_pkg::LAST_BIT_4W; // RL1

  // ----------------------------------------
  // receive shifter
  // ----------------------------------------
  epdsp_pkg::epdsp_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       flag_reg;
  logic       unit_done;
  logic [7:0] byte_now;
  logic       cmd_now;

  assign unit_done = rise && (bit_cnt_reg == last_idx);
  assign byte_now  = {shift_reg[6:0], sda_s}; // RL2 RL8
  // 3-wire ignores the select pin entirely
  assign cmd_now   = three_wire_reg ? ~flag_reg : ~dc_s; // RL4 RL7 RL9

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      flag_reg    <= 1'b0;
    end else if (cs_s || soft_clr) begin
      bit_cnt_reg <= 4'h0; // RL16
    end else if (rise) begin
      shift_reg <= byte_now; // RL2
      if (three_wire_reg && bit_cnt_reg == 4'h0) flag_reg <= sda_s; // RL8
      if (unit_done) bit_cnt_reg <= 4'h0;
      else bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // command decode and parameter capture
  // ----------------------------------------
  logic [7:0]  cur_cmd_reg;
  logic [1:0]  param_idx_reg;
  logic [23:0] drv_reg;
  logic [7:0]  gate_v_reg;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg     <= epdsp_pkg::ST_IDLE;
      cur_cmd_reg   <= 8'h00;
      param_idx_reg <= 2'h0;
    end else if (soft_clr || cs_s) begin
      state_reg <= epdsp_pkg::ST_IDLE;
    end else if (unit_done && cmd_now) begin
      cur_cmd_reg   <= byte_now; // RL4
      param_idx_reg <= 2'h0;
      if (epdsp_pkg::is_read_cmd(byte_now))
        state_reg <= epdsp_pkg::ST_READ; // RL5 RL10
      else
        state_reg <= epdsp_pkg::ST_RECV;
    end else if (unit_done) begin
      if (param_idx_reg != 2'h3) param_idx_reg <= param_idx_reg + 2'h1;
      if (state_reg == epdsp_pkg::ST_IDLE) state_reg <= epdsp_pkg::ST_RECV;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      drv_reg    <= epdsp_pkg::DRV_OUT_RST;
      gate_v_reg <= epdsp_pkg::GATE_V_RST;
    end else if (soft_clr) begin
      drv_reg    <= epdsp_pkg::DRV_OUT_RST;
      gate_v_reg <= epdsp_pkg::GATE_V_RST;
    end else if (unit_done && !cmd_now && state_reg != epdsp_pkg::ST_READ) begin
      if (cur_cmd_reg == epdsp_pkg::CMD_DRV_OUT) begin
        unique case (param_idx_reg)
          2'h0: drv_reg[7:0]   <= byte_now;
          2'h1: drv_reg[15:8]  <= byte_now;
          2'h2: drv_reg[23:16] <= byte_now;
          2'h3: drv_reg        <= drv_reg;
        endcase
      end
      if (cur_cmd_reg == epdsp_pkg::CMD_GATE_V && param_idx_reg == 2'h0)
        gate_v_reg <= byte_now;
    end
  end

  // ----------------------------------------
  // gate scan setup outputs
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_scan_start_gate <= epdsp_pkg::FIRST_GATE;
    end else if (drv_reg[epdsp_pkg::DRV_TB_POS]) begin
      o_scan_start_gate <= epdsp_pkg::LAST_GATE; // RL12
    end else begin
      o_scan_start_gate <= epdsp_pkg::FIRST_GATE; // RL12
    end
  end

  assign o_driver_output_setup   = drv_reg;
  assign o_gate_voltage_level    = gate_v_reg;
  assign o_gate_scan_direction   = drv_reg[epdsp_pkg::DRV_TB_POS];
  assign o_gate_interlace_mode   = drv_reg[epdsp_pkg::DRV_SM_POS];
  assign o_first_gate_select     = drv_reg[epdsp_pkg::DRV_GD_POS];
  assign o_gate_mux_lines        = drv_reg[epdsp_pkg::DRV_MUX_MSB:0];
  assign o_positive_gate_voltage = gate_v_reg[epdsp_pkg::GATE_V_MSB:0];

  // ----------------------------------------
  // delivery into the buffer
  // ----------------------------------------
  epdsp_byte_if in_if ();
  epdsp_byte_if out_if ();
  logic pend_valid_reg;
  logic pend_cmd_reg;
  logic [7:0] pend_data_reg;
  logic deliver;

  // bytes clocked in during a read phase are dummies, not data
  always_comb begin
    deliver = 1'b0;
    unique case (state_reg)
      epdsp_pkg::ST_IDLE: deliver = unit_done;
      epdsp_pkg::ST_RECV: deliver = unit_done;
      epdsp_pkg::ST_READ: deliver = unit_done && cmd_now;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_valid_reg <= 1'b0;
      pend_cmd_reg   <= 1'b0;
      pend_data_reg  <= 8'h00;
      o_overrun      <= 1'b0;
    end else if (soft_clr) begin
      pend_valid_reg <= 1'b0;
      o_overrun      <= 1'b0;
    end else begin
      if (deliver) begin
        pend_valid_reg <= 1'b1;
        pend_cmd_reg   <= cmd_now; // RL4
        pend_data_reg  <= byte_now;
        if (pend_valid_reg && !in_if.ready) o_overrun <= 1'b1;
      end else if (in_if.ready) begin
        pend_valid_reg <= 1'b0;
      end
    end
  end

  assign in_if.valid  = pend_valid_reg;
  assign in_if.is_cmd = pend_cmd_reg;
  assign in_if.data   = pend_data_reg;

  epdsp_two_buf u_buf (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_clear  (soft_clr),
    .in_if    (in_if),
    .out_if   (out_if)
  );

  // output stage keeps every user-side output on a flip-flop
  assign out_if.ready = !o_rx_valid || i_rx_ready;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_valid  <= 1'b0;
      o_rx_is_cmd <= 1'b0;
      o_rx_data   <= 8'h00;
    end else if (soft_clr) begin
      o_rx_valid <= 1'b0;
    end else if (out_if.ready) begin
      o_rx_valid  <= out_if.valid;
      o_rx_is_cmd <= out_if.is_cmd;
      o_rx_data   <= out_if.data;
    end
  end

  // ----------------------------------------
  // read-back transmitter
  // ----------------------------------------
  logic [7:0] tx_shift_reg;
  logic [2:0] tx_left_reg;
  logic       tx_start;

  // 4-wire answers right after a unit, 3-wire after the flag bit
  assign tx_start = fall && (state_reg == epdsp_pkg::ST_READ) &&
                    (tx_left_reg == 3'h0) &&
                    (three_wire_reg ? (bit_cnt_reg == 4'h1 && flag_reg)
                                    : (bit_cnt_reg == 4'h0)); // RL5 RL10

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_shift_reg <= 8'h00;
      tx_left_reg  <= 3'h0;
      o_sda        <= 1'b0;
      o_sda_oe_n   <= 1'b1;
      o_read_next  <= 1'b0;
      o_read_cmd   <= 8'h00;
    end else if (soft_clr || cs_s) begin
      tx_left_reg <= 3'h0;
      o_sda_oe_n  <= 1'b1;
      o_read_next <= 1'b0;
    end else begin
      o_read_next <= tx_start;
      if (unit_done && cmd_now) o_read_cmd <= byte_now;
      if (tx_start) begin
        o_sda        <= i_read_data[7]; // RL6
        tx_shift_reg <= {i_read_data[6:0], 1'b0};
        tx_left_reg  <= epdsp_pkg::TX_BITS;
        o_sda_oe_n   <= 1'b0;
      end else if (fall && tx_left_reg != 3'h0) begin
        o_sda        <= tx_shift_reg[7]; // RL6
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        tx_left_reg  <= tx_left_reg - 3'h1;
      end else if (rise && tx_left_reg == 3'h0) begin
        // last bit sampled: hand the line back before the host drives it
        o_sda_oe_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // busy
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) o_busy <= 1'b0;
    else o_busy <= i_waveform_active || i_temp_sensor_active; // RL15
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_cs_clears_count: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL16
    cs_s |=> (bit_cnt_reg == 4'h0))
    else $error("bit counter not cleared while deselected");

  a_strap_picks_frame: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL1
    cs_s |=> (three_wire_reg == $past(strap_s)))
    else $error("framing does not follow strap");

  a_four_wire_kind: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL4
    (unit_done && !three_wire_reg && !soft_clr && state_reg != epdsp_pkg::ST_READ)
    |=> (pend_valid_reg && pend_cmd_reg == !$past(dc_s)))
    else $error("4-wire byte kind does not follow select");

  a_three_wire_kind: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL9
    (unit_done && three_wire_reg && !soft_clr && state_reg != epdsp_pkg::ST_READ)
    |=> (pend_cmd_reg == !$past(flag_reg)))
    else $error("3-wire byte kind does not follow flag");

  a_byte_lsb_last: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL2
    (deliver && !soft_clr) |=> (pend_data_reg[0] == $past(sda_s)
                               && pend_data_reg[7:1] == $past(shift_reg[6:0])))
    else $error("received byte misaligned");

  a_unit_length: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL8
    unit_done |-> (bit_cnt_reg == (three_wire_reg ? 4'h8 : 4'h7)))
    else $error("unit length wrong for framing");

  a_tx_msb_order: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL6
    (fall && !tx_start && tx_left_reg != 3'h0 && !soft_clr)
    |=> (o_sda == $past(tx_shift_reg[7]) && !o_sda_oe_n))
    else $error("read bit not shifted out in order");

  a_tx_load: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL10
    (tx_start && !soft_clr) |=> (o_sda == $past(i_read_data[7]) && o_read_next
                                 && tx_left_reg == 3'h7))
    else $error("read byte not loaded on its falling edge");

  a_busy_follows: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL15
    (i_waveform_active || i_temp_sensor_active) |=> o_busy)
    else $error("busy not raised");

  a_scan_start: assert property (@(posedge i_clock) disable iff (!i_resetn) // RL12
    $rose(o_gate_scan_direction) |=> (o_scan_start_gate == 9'h127))
    else $error("scan does not start at last gate");

endmodule

// ---- test/epdsp_host_model.sv ----
// host microcontroller model driving the serial pins of the port
`timescale 1ns/1ps
module epdsp_host_model (
  // clock and framing choice
  input  wire logic i_clock,
  input  wire logic i_three_wire,
  // serial pins
  input  wire logic i_sda_wire,
  output logic      o_cs_n,
  output logic      o_dc,
  output logic      o_sclk,
  output logic      o_host_sda
);
  // called once at time zero by the bench, so each pin has one driving process
  task automatic park();
    o_cs_n     = 1'b1;
    o_dc       = 1'b0;
    o_sclk     = 1'b0;
    o_host_sda = 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // one bit with a 4-cycle half period (800 ns serial clock), ending high
  task automatic put_bit(input logic b);
    o_host_sda <= b;
    o_sclk     <= 1'b0;
    tick(4);
    o_sclk     <= 1'b1;
    tick(4);
  endtask

  task automatic begin_frame();
    o_cs_n <= 1'b0;
    tick(4);
  endtask

  // clock parks low only after chip select is high, so no stray fall is seen
  task automatic end_frame();
    tick(2);
    o_cs_n <= 1'b1;
    tick(2);
    o_sclk <= 1'b0;
    tick(4);
  endtask

  task automatic send_unit(input logic is_cmd, input logic [7:0] b);
    if (i_three_wire) begin
      o_dc <= 1'b0;
      put_bit(~is_cmd);
    end else begin
      o_dc <= ~is_cmd;
    end
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
  endtask

  // released line shows a changing pattern so a missing driver cannot match
  task automatic read_byte(output logic [7:0] b);
    if (i_three_wire) put_bit(1'b1);
    else o_dc <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      o_host_sda <= ~o_host_sda;
      o_sclk     <= 1'b0;
      tick(4);
      o_sclk     <= 1'b1;
      // sample before the device sees this rise and may release the line
      tick(2);
      b[i] = i_sda_wire;
      tick(2);
    end
  endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench of the e-paper serial host port
`timescale 1ns/1ps
module tb_top;
  logic        i_clock, i_resetn, i_active_low_reset_in, i_bus_framing_strap;
  logic        i_cs_n, i_dc, i_sclk, i_sda, host_sda, o_sda, o_sda_oe_n, o_busy;
  logic        i_waveform_active, i_temp_sensor_active, o_read_next, i_rx_ready;
  logic        o_rx_valid, o_rx_is_cmd, o_overrun, hold_off, allow_extra;
  logic        o_gate_scan_direction, o_first_gate_select, o_gate_interlace_mode;
  logic [7:0]  i_read_data, o_read_cmd, o_rx_data, o_gate_voltage_level, got, exp_rd;
  logic [23:0] o_driver_output_setup;
  logic [4:0]  o_positive_gate_voltage;
  logic [8:0]  o_gate_mux_lines, o_scan_start_gate;
  logic [8:0]  exp_q[$];
  logic [7:0]  rd_cmds[6];
  int          n_fail, n_tests;

  assign i_sda = (o_sda_oe_n === 1'b0) ? o_sda : host_sda;

  epdsp_serial_host_port dut (
    .i_clock                 (i_clock),
    .i_resetn                (i_resetn),
    .i_active_low_reset_in   (i_active_low_reset_in),
    .i_bus_framing_strap     (i_bus_framing_strap),
    .i_cs_n                  (i_cs_n),
    .i_dc                    (i_dc),
    .i_sclk                  (i_sclk),
    .i_sda                   (i_sda),
    .o_sda                   (o_sda),
    .o_sda_oe_n              (o_sda_oe_n),
    .o_busy                  (o_busy),
    .i_waveform_active       (i_waveform_active),
    .i_temp_sensor_active    (i_temp_sensor_active),
    .i_read_data             (i_read_data),
    .o_read_cmd              (o_read_cmd),
    .o_read_next             (o_read_next),
    .o_rx_valid              (o_rx_valid),
    .o_rx_is_cmd             (o_rx_is_cmd),
    .o_rx_data               (o_rx_data),
    .i_rx_ready              (i_rx_ready),
    .o_overrun               (o_overrun),
    .o_driver_output_setup   (o_driver_output_setup),
    .o_gate_voltage_level    (o_gate_voltage_level),
    .o_gate_scan_direction   (o_gate_scan_direction),
    .o_first_gate_select     (o_first_gate_select),
    .o_gate_interlace_mode   (o_gate_interlace_mode),
    .o_positive_gate_voltage (o_positive_gate_voltage),
    .o_gate_mux_lines        (o_gate_mux_lines),
    .o_scan_start_gate       (o_scan_start_gate)
  );

  epdsp_host_model host (
    .i_clock(i_clock), .i_three_wire(i_bus_framing_strap), .i_sda_wire(i_sda),
    .o_cs_n(i_cs_n), .o_dc(i_dc), .o_sclk(i_sclk), .o_host_sda(host_sda)
  );

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    n_tests++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic is_cmd, input logic [7:0] b);
    exp_q.push_back({is_cmd, b});
    host.send_unit(is_cmd, b);
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 400) begin
      @(posedge i_clock);
      k++;
    end
    if (exp_q.size() > 0) begin
      n_fail++;
      test_done();
    end
  endtask

  // consumer side of the byte stream, stalling every other cycle
  always @(posedge i_clock) begin
    // reset gives both a single driving process and a known start
    i_rx_ready <= i_resetn && !hold_off && !i_rx_ready;
    if (!i_resetn) i_read_data <= 8'h5A;
    else if (read_next_seen()) i_read_data <= i_read_data + 8'h01;
    if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1) begin
      if (exp_q.size() > 0) chk({o_rx_is_cmd, o_rx_data}, exp_q.pop_front());
      else if (!allow_extra) chk({o_rx_is_cmd, o_rx_data}, 32'h0000_0200);
    end
  end

  function automatic logic read_next_seen();
    return o_read_next === 1'b1;
  endfunction

  initial begin
    host.park();
    i_resetn = 1'b0;
    i_active_low_reset_in = 1'b1;
    i_bus_framing_strap = 1'b0;
    i_waveform_active = 1'b0;
    i_temp_sensor_active = 1'b0;
    hold_off = 1'b0;
    allow_extra = 1'b0;
    n_fail = 0;
    n_tests = 0;
    exp_rd = 8'h5A;
    rd_cmds = '{8'h1B, 8'h27, 8'h2D, 8'h2E, 8'h2F, 8'h35};
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    host.tick(6);
    chk(o_driver_output_setup, 24'h00_0127);
    chk(o_gate_voltage_level, 8'h00);
    chk(o_scan_start_gate, 9'h000);
    chk({o_busy, o_sda_oe_n, o_rx_valid}, 3'h2);
    // ----------------------------------------
    // 4-wire setup writes
    // ----------------------------------------
    host.begin_frame();
    wr(1'b1, 8'h01);
    wr(1'b0, 8'h2B);
    wr(1'b0, 8'h01);
    wr(1'b0, 8'h05);
    wr(1'b1, 8'h03);
    wr(1'b0, 8'hF3);
    host.end_frame();
    drain();
    chk(o_driver_output_setup, 24'h05_012B);
    chk({o_gate_scan_direction, o_gate_interlace_mode, o_first_gate_select}, 3'h5);
    chk(o_gate_mux_lines, 9'h12B);
    chk(o_scan_start_gate, 9'h127);
    chk({o_gate_voltage_level, 3'h0, o_positive_gate_voltage}, 16'hF3_13);
    // ----------------------------------------
    // busy follows core activity
    // ----------------------------------------
    i_waveform_active <= 1'b1;
    host.tick(3);
    chk(o_busy, 1'b1);
    i_waveform_active <= 1'b0;
    i_temp_sensor_active <= 1'b1;
    host.tick(3);
    chk(o_busy, 1'b1);
    i_temp_sensor_active <= 1'b0;
    host.tick(3);
    chk(o_busy, 1'b0);
    // ----------------------------------------
    // clocks while deselected, then a cut-short unit
    // ----------------------------------------
    for (int i = 0; i < 8; i++) host.put_bit(i[0]);
    host.begin_frame();
    for (int i = 0; i < 3; i++) host.put_bit(1'b1);
    host.end_frame();
    host.begin_frame();
    wr(1'b0, 8'h3C);
    host.end_frame();
    drain();
    // ----------------------------------------
    // every read command, alternating framings
    // ----------------------------------------
    for (int c = 0; c < 6; c++) begin
      i_bus_framing_strap <= c[0];
      host.tick(2);
      host.begin_frame();
      wr(1'b1, rd_cmds[c]);
      for (int r = 0; r < 2; r++) begin
        host.read_byte(got);
        chk(got, exp_rd);
        exp_rd = exp_rd + 8'h01;
      end
      host.end_frame();
      drain();
      chk({o_read_cmd, 7'h00, o_sda_oe_n}, {rd_cmds[c], 8'h01});
    end
    // ----------------------------------------
    // 3-wire setup writes with a surplus parameter
    // ----------------------------------------
    i_bus_framing_strap <= 1'b1;
    host.tick(2);
    host.begin_frame();
    wr(1'b1, 8'h01);
    wr(1'b0, 8'h10);
    wr(1'b0, 8'h02);
    wr(1'b0, 8'h00);
    wr(1'b0, 8'h77);
    wr(1'b1, 8'h03);
    wr(1'b0, 8'h05);
    host.end_frame();
    drain();
    chk(o_driver_output_setup, 24'h00_0210);
    chk({o_scan_start_gate, o_gate_mux_lines}, 18'h0_0010);
    chk(o_positive_gate_voltage, 5'h05);
    // ----------------------------------------
    // receiver stalled until a word is lost, then pin reset
    // ----------------------------------------
    i_bus_framing_strap <= 1'b0;
    hold_off <= 1'b1;
    allow_extra = 1'b1;
    host.tick(2);
    host.begin_frame();
    for (int i = 0; i < 3; i++) wr(1'b0, 8'hC0 + i[7:0]);
    host.tick(8);
    chk(o_overrun, 1'b0);
    for (int i = 0; i < 3; i++) host.send_unit(1'b0, 8'hD0);
    host.end_frame();
    host.tick(8);
    chk(o_overrun, 1'b1);
    hold_off <= 1'b0;
    drain();
    host.tick(30);
    i_active_low_reset_in <= 1'b0;
    host.tick(5);
    chk({o_overrun, o_rx_valid, o_driver_output_setup}, 26'h000_0127);
    i_active_low_reset_in <= 1'b1;
    host.tick(6);
    allow_extra = 1'b0;
    test_done();
  end
endmodule
